/* File: hdl/reset_and_wakeup_control.v */
`timescale 1ns/100ps
`include "reset_wakeup_defs.vh"

module reset_and_wakeup_control #(
  parameter NUM_IRQ = `IRQ_COUNT,
  parameter NUM_PINS = 32,
  parameter PRIO_W = `PRIO_BITS
) (
  input wire clk,
  input wire srst,
  input wire [`SRC_COUNT-1:0] reset_src,
  input wire [2:0] power_mode,
  input wire [NUM_PINS-1:0] pin_irq_flag,
  input wire [NUM_PINS-1:0] pin_irq_en,
  input wire [3:0] periph_wake_req,
  input wire [7:0] periph_clk_src,
  input wire low_power_timer_wake,
  input wire rtc_wake,
  input wire nmi_wake,
  input wire [NUM_IRQ-1:0] irq_req,
  input wire [NUM_IRQ*PRIO_W-1:0] priority_field_registers,
  input wire irq_ack,
  output reg [`MOD_COUNT-1:0] module_reset_ff,
  output reg retain_partial_ff,
  output reg sys_reset_active_ff,
  output wire async_wake,
  output reg clock_resume_ff,
  output reg irq_valid_ff,
  output reg [4:0] irq_vector_ff,
  output reg [PRIO_W-1:0] irq_level_ff
);

  localparam KIND_NONE = 2'h0;
  localparam KIND_FULL = 2'h1;
  localparam KIND_PIN = 2'h2;
  localparam KIND_SYS = 2'h3;

  wire por_class;
  wire pin_class;
  wire dog_class;
  wire sys_class;
  wire any_src;

  wire deep_sleep;
  wire pin_wake;
  wire periph_wake;
  wire timer_wake;
  wire reset_wake;
  wire [3:0] periph_ok;

  wire [3:0] nxt_hold_cnt;
  reg [1:0] kind_ff;
  reg [1:0] nxt_kind;

  reg [NUM_IRQ-1:0] pending_ff;
  reg [NUM_IRQ-1:0] nxt_pending;
  reg found;
  reg [4:0] best_idx;
  reg [PRIO_W-1:0] best_lvl;
  reg [PRIO_W-1:0] cur_lvl;
  integer i;
  genvar g;

  // Source classes
  assign por_class = reset_src[`SRC_POR]
    | reset_src[`SRC_LOW_VOLT];
  assign pin_class = reset_src[`SRC_PIN];
  assign dog_class = reset_src[`SRC_WATCHDOG]
    | reset_src[`SRC_CLK_LOSS]
    | reset_src[`SRC_LOCK_LOSS]
    | reset_src[`SRC_SACK]
    | reset_src[`SRC_SW]
    | reset_src[`SRC_LOCKUP]
    | reset_src[`SRC_DAP]
    | reset_src[`SRC_DBG];
  assign sys_class = pin_class | dog_class;
  assign any_src = srst | por_class | sys_class;

  // Hold reset until sources gone for a few clocks
  release_stretch #(
    .CNT_W(4),
    .LOAD(`RST_HOLD_CYCLES)
  ) release_stretch_i (
    .clk(clk),
    .load(any_src),
    .count_ff(),
    .nxt_count(nxt_hold_cnt)
  );

  always @(posedge clk) begin
    sys_reset_active_ff <= (nxt_hold_cnt != 4'h0);
    kind_ff <= nxt_kind;
  end

  // Reset kind, upgraded by a stronger source until release
  always @* begin
    nxt_kind = kind_ff;
    if (srst | por_class) begin
      nxt_kind = KIND_FULL;
    end else begin
      case (kind_ff)
        KIND_NONE: begin
          if (pin_class) begin
            nxt_kind = KIND_PIN;
          end else if (dog_class) begin
            nxt_kind = KIND_SYS;
          end
        end
        KIND_PIN: begin
          if (nxt_hold_cnt == 4'h0) begin
            nxt_kind = KIND_NONE;
          end
        end
        KIND_SYS: begin
          if (pin_class) begin
            nxt_kind = KIND_PIN;
          end else if (nxt_hold_cnt == 4'h0) begin
            nxt_kind = KIND_NONE;
          end
        end
        KIND_FULL: begin
          if (nxt_hold_cnt == 4'h0) begin
            nxt_kind = KIND_NONE;
          end
        end
        default: begin
          nxt_kind = KIND_NONE;
        end
      endcase
    end
  end

  // Module reset distribution
  always @(posedge clk) begin
    if (nxt_hold_cnt != 4'h0) begin
      module_reset_ff <= {`MOD_COUNT{1'b1}};
      if (nxt_kind != KIND_FULL) begin
        module_reset_ff[`MOD_LPT] <= 1'b0;
        module_reset_ff[`MOD_RTC] <= 1'b0;
      end
      // Retention only for watchdog-class sources
      retain_partial_ff <= (nxt_kind == KIND_SYS);
    end else begin
      module_reset_ff <= {`MOD_COUNT{1'b0}};
      retain_partial_ff <= 1'b0;
    end
    if (srst) begin
      module_reset_ff <= {`MOD_COUNT{1'b1}};
      retain_partial_ff <= 1'b0;
    end
  end

  // Wake path, combinational so it works without a clock
  assign deep_sleep = (power_mode == `MODE_PSTOP)
    | (power_mode == `MODE_STOP)
    | (power_mode == `MODE_LP_STOP);
  assign pin_wake = |(pin_irq_flag & pin_irq_en);
  assign timer_wake = low_power_timer_wake | rtc_wake;
  assign reset_wake = reset_src[`SRC_PIN] | reset_src[`SRC_WATCHDOG];

  // One clock-source gate per peripheral wake request
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_wake_gate
      wake_clock_gate #(
        .SEL_W(2)
      ) wake_clock_gate_i (
        .clk_sel(periph_clk_src[2*g +: 2]),
        .wake_req(periph_wake_req[g]),
        .wake_ok(periph_ok[g])
      );
    end
  endgenerate

  assign periph_wake = |periph_ok;

  // Wait modes are left to the interrupt controller
  assign async_wake = deep_sleep & (pin_wake
    | periph_wake
    | timer_wake
    | nmi_wake
    | reset_wake);

  always @(posedge clk) begin
    if (srst) begin
      clock_resume_ff <= 1'b0;
    end else begin
      clock_resume_ff <= async_wake;
    end
  end

  // Interrupt controller: pending latch and priority selection
  always @* begin
    nxt_pending = pending_ff | irq_req;
    if (irq_ack && irq_valid_ff) begin
      nxt_pending[irq_vector_ff] = irq_req[irq_vector_ff];
    end
  end

  always @* begin
    found = 1'b0;
    best_idx = 5'h00;
    best_lvl = {PRIO_W{1'b1}};
    cur_lvl = {PRIO_W{1'b0}};
    for (i = 0; i < NUM_IRQ; i = i + 1) begin
      cur_lvl = priority_field_registers[i*PRIO_W +: PRIO_W];
      if (pending_ff[i] && (!found || cur_lvl < best_lvl)) begin
        found = 1'b1;
        best_idx = i[4:0];
        best_lvl = cur_lvl;
      end
    end
  end

  always @(posedge clk) begin
    if (srst || sys_reset_active_ff) begin
      pending_ff <= {NUM_IRQ{1'b0}};
      irq_valid_ff <= 1'b0;
      irq_vector_ff <= 5'h00;
      irq_level_ff <= {PRIO_W{1'b0}};
    end else begin
      pending_ff <= nxt_pending;
      // Wait modes woken directly by the controller, no async unit
      irq_valid_ff <= found && !(irq_ack && irq_valid_ff);
      irq_vector_ff <= best_idx;
      irq_level_ff <= best_lvl;
    end
  end

endmodule

// Reload while any source stands, then count down to zero
module release_stretch #(
  parameter CNT_W = 4,
  parameter [CNT_W-1:0] LOAD = `RST_HOLD_CYCLES
) (
  input wire clk,
  input wire load,
  output reg [CNT_W-1:0] count_ff,
  output wire [CNT_W-1:0] nxt_count
);
  reg [CNT_W-1:0] nxt_value;

  always @* begin
    if (load) begin
      nxt_value = LOAD;
    end else if (count_ff != {CNT_W{1'b0}}) begin
      nxt_value = count_ff - {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      nxt_value = {CNT_W{1'b0}};
    end
  end

  assign nxt_count = nxt_value;

  always @(posedge clk) begin
    count_ff <= nxt_value;
  end
endmodule

// Peripheral wake passes only on slow internal or external oscillator
module wake_clock_gate #(
  parameter SEL_W = 2
) (
  input wire [SEL_W-1:0] clk_sel,
  input wire wake_req,
  output wire wake_ok
);
  wire sel_slow;
  wire sel_ext;

  assign sel_slow = (clk_sel == `CLKSRC_SLOW);
  assign sel_ext = (clk_sel == `CLKSRC_EXT);
  assign wake_ok = wake_req & (sel_slow | sel_ext);
endmodule

/* File: hdl/reset_wakeup_defs.vh */
`ifndef RESET_WAKEUP_DEFS_VH
`define RESET_WAKEUP_DEFS_VH

// Reset source bit positions in the source vector
`define SRC_POR 0
`define SRC_LOW_VOLT 1
`define SRC_PIN 2
`define SRC_WATCHDOG 3
`define SRC_CLK_LOSS 4
`define SRC_LOCK_LOSS 5
`define SRC_SACK 6
`define SRC_SW 7
`define SRC_LOCKUP 8
`define SRC_DAP 9
`define SRC_DBG 10
`define SRC_COUNT 11

// Module reset output bit positions
`define MOD_POWER 0
`define MOD_SIU 1
`define MOD_MODE 2
`define MOD_RST 3
`define MOD_PIN 4
`define MOD_WATCHDOG 5
`define MOD_CLK 6
`define MOD_LPT 7
`define MOD_RTC 8
`define MOD_OTHER 9
`define MOD_COUNT 10

// Power modes: run and low-power
`define MODE_RUN 3'h0
`define MODE_WAIT 3'h1
`define MODE_LP_WAIT 3'h2
`define MODE_PSTOP 3'h3
`define MODE_STOP 3'h4
`define MODE_LP_STOP 3'h5

// Peripheral wake clock source
`define CLKSRC_SLOW 2'h0
`define CLKSRC_EXT 2'h1
`define CLKSRC_OTHER 2'h2

// Interrupt controller sizing
`define IRQ_COUNT 32
`define PRIO_BITS 2
`define PRIO_LEVELS 4

// Reset release stretch in cycles
`define RST_HOLD_CYCLES 4'h4

`endif

/* File: verification/reset_and_wakeup_control_asserts.sv */
`timescale 1ns/100ps
module reset_wakeup_checker(
  input wire clk,
  input wire srst,
  input wire [10:0] reset_src,
  input wire [2:0] power_mode,
  input wire [9:0] module_reset_ff,
  input wire retain_partial_ff,
  input wire sys_reset_active_ff,
  input wire async_wake,
  input wire clock_resume_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire deep = power_mode > 3'h2 && power_mode < 3'h6;
  wire idle = module_reset_ff == 10'h000;
  sequence quiet_s; !(|reset_src) [*8]; endsequence
  sequence hold_s; (|module_reset_ff) [*3]; endsequence
  a_por_full: assert property (reset_src[0] |=> module_reset_ff == 10'h3FF) else $error("por");
  a_pin_keep: assert property (idle && reset_src == 11'h004 |=> module_reset_ff == 10'h27F && !retain_partial_ff)
    else $error("pin");
  a_sys_keep: assert property (idle && |reset_src[10:3] && !(|reset_src[2:0])
    |=> module_reset_ff == 10'h27F && retain_partial_ff) else $error("sys");
  a_release_all: assert property (quiet_s |-> idle) else $error("release");
  a_hold_reset: assert property ($fell(|reset_src) |-> hold_s) else $error("hold");
  a_req_active: assert property (|reset_src |=> sys_reset_active_ff) else $error("active");
  a_wake_mode: assert property (async_wake |-> deep) else $error("mode");
  a_clock_resume: assert property (async_wake |=> clock_resume_ff) else $error("resume");
endmodule
bind reset_and_wakeup_control reset_wakeup_checker reset_wakeup_checker_i(.*);

/* File: verification/irq_servicer.sv */
`timescale 1ns/100ps
module irq_servicer(
  input wire clk,
  input wire [3:0] delay,
  input wire irq_valid_ff,
  output reg irq_ack
);
  reg [3:0] wait_ff = 4'h0;
  initial irq_ack = 1'b0;
  // Services the pending vector after a delay
  always @(posedge clk) begin
    irq_ack <= irq_valid_ff && !irq_ack && wait_ff >= delay;
    wait_ff <= (irq_valid_ff && !irq_ack) ? wait_ff + 4'h1 : 4'h0;
  end
endmodule

/* File: verification/test_reset_and_wakeup_control.sv */
`timescale 1ns/100ps
module test_reset_and_wakeup_control;
  reg clk, srst, low_power_timer_wake, rtc_wake, nmi_wake;
  reg [10:0] reset_src;
  reg [2:0] power_mode;
  reg [31:0] pin_irq_flag, pin_irq_en, irq_req, rnd;
  reg [3:0] periph_wake_req, delay;
  reg [7:0] periph_clk_src;
  reg [63:0] priority_field_registers;
  wire irq_ack, async_wake, retain_partial_ff, irq_valid_ff, sys_reset_active_ff, clock_resume_ff;
  wire [9:0] module_reset_ff;
  wire [4:0] irq_vector_ff;
  wire [1:0] irq_level_ff;
  integer fail_count = 0, n_tests = 0, cyc = 0, i;
  reg [10:0] rq[$];
  reg [6:0] iq[$];
  reset_and_wakeup_control reset_and_wakeup_control_i(.*);
  irq_servicer irq_servicer_i(.*);
  function [31:0] xs(input [31:0] x);
    reg [31:0] a, b;
    begin
      a = x ^ (x << 13);
      b = a ^ (a >> 17);
      xs = b ^ (b << 5);
    end
  endfunction
  task check(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("mismatches %0d checks %0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      fail_count = fail_count + 1;
      final_report;
    end
    if (!srst && $rose(|module_reset_ff) && rq.size() > 0)
      check({module_reset_ff, retain_partial_ff}, rq.pop_front());
    if (irq_valid_ff && irq_ack && iq.size() > 0)
      check({irq_vector_ff, irq_level_ff}, iq.pop_front());
  end
  initial begin
    {srst, reset_src, power_mode, low_power_timer_wake, rtc_wake, nmi_wake} = {1'b1, 17'h0};
    {pin_irq_flag, pin_irq_en, irq_req, periph_wake_req, periph_clk_src, delay} = 0;
    rnd = 32'hEA31A738;
    repeat (3) @(negedge clk);
    srst = 0;
    repeat (10) @(negedge clk);
    for (i = 0; i < 11; i = i + 1) begin
      rq.push_back(i < 2 ? 11'h7FE : {10'h27F, i > 2});
      rnd = xs(rnd);
      reset_src = 11'h1 << i;
      repeat (1 + rnd[1:0]) @(negedge clk);
      reset_src = 0;
      repeat (8) @(negedge clk);
    end
    for (i = 0; i < 6; i = i + 1) begin
      power_mode = i;
      rnd = xs(rnd);
      pin_irq_flag = rnd | 1;
      pin_irq_en = ~rnd | 1;
      #5 check(async_wake, i > 2);
      pin_irq_en = 0;
      periph_wake_req = 4'h1;
      periph_clk_src = 8'h02;
      #5 check(async_wake, 0);
      periph_clk_src = 8'h01;
      #5 check(async_wake, i > 2);
      periph_wake_req = 0;
      @(negedge clk);
    end
    power_mode = 0;
    repeat (2) begin
      rnd = xs(rnd);
      priority_field_registers = {64{1'b1}};
      priority_field_registers[2 * rnd[4:0] +: 2] = 2'h1;
      priority_field_registers[2 * (rnd[4:0] ^ 5'h10) +: 2] = 2'h2;
      iq.push_back({rnd[4:0], 2'h1});
      iq.push_back({rnd[4:0] ^ 5'h10, 2'h2});
      irq_req = (32'h1 << rnd[4:0]) | (32'h1 << (rnd[4:0] ^ 5'h10));
      @(negedge clk);
      irq_req = 0;
      repeat (30) @(negedge clk);
      delay = 4'h5;
    end
    final_report;
  end
endmodule
